/* File: rtl/lsq_pkg.sv */
// Shared constants and types for the limit switch status query block
package lsq_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_PROCESSED = 8'h0C;
  localparam logic [7:0] OFS_RAW = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_REPLY0 = 8'h20;
  localparam int REPLY_WORDS = 5;

  // Command register fields
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_SINGLE_BIT = 4;
  localparam int CMD_INDEX_LSB = 8;

  // Status register fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_LEN_LSB = 8;

  // Config register fields: enable, polarity, axis direction, swap
  localparam int CFG_EN_LSB = 0;
  localparam int CFG_POL_LSB = 8;
  localparam int CFG_DIR_LSB = 16;
  localparam int CFG_SWAP_LSB = 20;
  localparam logic [31:0] CFG_RESET = 32'h0000_00FF;

  // Reply lengths, terminator included
  localparam logic [4:0] LEN_RAW_ALL = 5'h09;
  localparam logic [4:0] LEN_RAW_ONE = 5'h02;
  localparam logic [4:0] LEN_STATUS = 5'h11;
  localparam int REPLY_MAX = 17;

  // ASCII characters
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ONE = 8'h31;
  localparam logic [7:0] CH_DASH = 8'h2D;
  localparam logic [7:0] CH_CAL = 8'h41;
  localparam logic [7:0] CH_RANGE = 8'h44;
  localparam logic [7:0] CH_LIMIT = 8'h4C;
  localparam logic [7:0] CH_TERM = 8'h0D;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_RAW,
    KIND_STATUS,
    KIND_BAD
  } lsq_kind_e;

  typedef enum {
    SQ_IDLE,
    SQ_EMIT,
    SQ_TERM
  } lsq_seq_e;

endpackage

/* File: rtl/lsq_fmt_if.sv */
// Formatter request and answer between sequencer and character builder
`timescale 1ns/1ps
interface lsq_fmt_if;
  lsq_pkg::lsq_kind_e kind;
  logic single;
  logic [2:0] index;
  logic [3:0] pos;
  logic [7:0] ch;

  modport seq (output kind, output single, output index, output pos,
               input ch);
  modport fmt (input kind, input single, input index, input pos,
               output ch);
endinterface

/* File: rtl/lsq_reply_fmt.sv */
// Builds one reply character from pin levels and progress flags
`timescale 1ns/1ps
module lsq_reply_fmt (
  lsq_fmt_if.fmt f,
  input wire logic [7:0] levels,
  input wire logic [3:0] cal_flag,
  input wire logic [3:0] range_flag,
  input wire logic [3:0] lower_flag,
  input wire logic [3:0] upper_flag
);

  logic raw_bit;
  logic [1:0] axis;

  // Raw bit straight from the pin, no polarity or swap applied
  always_comb begin
    raw_bit = f.single ? levels[f.index] : levels[f.pos[2:0]];
    axis = f.pos[1:0];
  end

  // Groups of four, one character per axis in X Y Z A order
  always_comb begin
    f.ch = lsq_pkg::CH_DASH;
    if (f.kind == lsq_pkg::KIND_RAW) begin
      f.ch = raw_bit ? lsq_pkg::CH_ONE : lsq_pkg::CH_ZERO;
    end else begin
      unique case (f.pos[3:2])
        2'h0: if (cal_flag[axis]) f.ch = lsq_pkg::CH_CAL;
        2'h1: if (range_flag[axis]) f.ch = lsq_pkg::CH_RANGE;
        2'h2: if (lower_flag[axis]) f.ch = lsq_pkg::CH_LIMIT;
        2'h3: if (upper_flag[axis]) f.ch = lsq_pkg::CH_LIMIT;
      endcase
    end
  end

endmodule

/* File: rtl/lsq_limit_status_query.sv */
// Limit switch query handler with AXI4-Lite command and reply registers
//
// Summary of operation
// - Raw level query without index replies with eight 0/1 characters.
// - Each raw character is 0 for a low pin, 1 for high.
// - With an index the reply is that one input's level character.
// - Raw levels are reported even for disabled switches.
// - Raw levels ignore polarity, axis direction and lower/upper swap.
// - Connector pairs one to four belong to axes X, Y, Z, A.
// - Raw characters 0..7 go pair by pair, lower input then upper.
// - Status query returns sixteen characters, four groups in X Y Z A order.
// - Positions 0..3 show calibration as dash or A.
// - Positions 4..7 show range measurement as dash or D.
// - Positions 8..11 show lower limit change as dash or L.
// - Positions 12..15 show upper limit change as dash or L.
// - Every status position reads dash after power on.
// - Completed calibration of an axis shows A.
// - Completed range measurement of an axis shows D.
// - Host change of a software limit shows L in that position.
// - Processed view masks disabled switches, applies polarity, direction.
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
module lsq_limit_status_query #(
  parameter int AXES = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  // Limit inputs, bit 0 lower (origin), bit 1 upper (end)
  input wire logic [1:0] x_limit_input_pair,
  input wire logic [1:0] y_limit_input_pair,
  input wire logic [1:0] z_limit_input_pair,
  input wire logic [1:0] a_limit_input_pair,
  // Completion pulses from the motion engine, one bit per axis
  input wire logic [AXES-1:0] cal_done,
  input wire logic [AXES-1:0] range_measure_command_done,
  input wire logic [AXES-1:0] lower_limit_set,
  input wire logic [AXES-1:0] upper_limit_set,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [7:0] levels;
  logic [3:0] cal_flag;
  logic [3:0] range_flag;
  logic [3:0] lower_flag;
  logic [3:0] upper_flag;
  logic [31:0] config_reg;
  logic [7:0] processed;
  logic aw_got;
  logic w_got;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic cmd_write;
  logic busy;
  logic done;
  logic [4:0] reply_len;
  logic [3:0] pos;
  logic single;
  logic [2:0] index;
  lsq_pkg::lsq_kind_e kind;
  lsq_pkg::lsq_seq_e state;
  lsq_pkg::lsq_kind_e cmd_kind;
  logic [7:0] reply_mem [0:lsq_pkg::REPLY_MAX-1];
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic status_read;
  logic seq_finish;

  lsq_fmt_if fmt_bus ();

  // Pins packed pair by pair, lower before upper, X first
  assign levels = {a_limit_input_pair, z_limit_input_pair,
                   y_limit_input_pair, x_limit_input_pair};

  assign fmt_bus.kind = kind;
  assign fmt_bus.single = single;
  assign fmt_bus.index = index;
  assign fmt_bus.pos = pos;

  lsq_reply_fmt u_fmt (
    .f(fmt_bus.fmt),
    .levels(levels),
    .cal_flag(cal_flag),
    .range_flag(range_flag),
    .lower_flag(lower_flag),
    .upper_flag(upper_flag)
  );

  // Progress flags are sticky until power-on reset only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_flag <= 4'h0;
      range_flag <= 4'h0;
      lower_flag <= 4'h0;
      upper_flag <= 4'h0;
    end else begin
      cal_flag <= cal_flag | cal_done[3:0];
      range_flag <= range_flag | range_measure_command_done[3:0];
      lower_flag <= lower_flag | lower_limit_set[3:0];
      upper_flag <= upper_flag | upper_limit_set[3:0];
    end
  end

  // Processed view: swap pair when direction and swap disagree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      processed <= 8'h00;
    end else begin
      for (int a = 0; a < 4; a++) begin
        logic sw;
        logic [1:0] lv;
        sw = config_reg[lsq_pkg::CFG_DIR_LSB + a]
             ^ config_reg[lsq_pkg::CFG_SWAP_LSB + a];
        lv = levels[2*a +: 2]
             ^ config_reg[lsq_pkg::CFG_POL_LSB + 2*a +: 2];
        if (sw) begin
          lv = {lv[0], lv[1]};
        end
        processed[2*a +: 2] <= lv
          & config_reg[lsq_pkg::CFG_EN_LSB + 2*a +: 2];
      end
    end
  end

  // Write address channel; ready only while no address is held and no response is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_got <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel, accepted independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_got <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign cmd_write = do_write && (aw_addr == lsq_pkg::OFS_CMD)
                     && w_strb[0] && w_strb[1];
  assign cmd_kind = lsq_pkg::lsq_kind_e'(
    w_data[lsq_pkg::CMD_KIND_LSB +: 2]);

  // Write response after both halves have arrived
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= lsq_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == lsq_pkg::OFS_CMD || aw_addr == lsq_pkg::OFS_CONFIG) begin
        s_axi_bresp <= lsq_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= lsq_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration register with byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= lsq_pkg::CFG_RESET;
    end else if (do_write && aw_addr == lsq_pkg::OFS_CONFIG) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          config_reg[8*b +: 8] <= w_data[8*b +: 8];
        end
      end
    end
  end

  // Query sequencer: one character per cycle, then the terminator
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= lsq_pkg::SQ_IDLE;
      kind <= lsq_pkg::KIND_NONE;
      single <= 1'b0;
      index <= 3'h0;
      pos <= 4'h0;
      reply_len <= 5'h00;
    end else begin
      unique case (state)
        lsq_pkg::SQ_IDLE: begin
          // Commands arriving while busy are dropped, not queued
          if (cmd_write && (cmd_kind == lsq_pkg::KIND_RAW
                            || cmd_kind == lsq_pkg::KIND_STATUS)) begin
            kind <= cmd_kind;
            single <= (cmd_kind == lsq_pkg::KIND_RAW)
                      && w_data[lsq_pkg::CMD_SINGLE_BIT];
            index <= w_data[lsq_pkg::CMD_INDEX_LSB +: 3];
            pos <= 4'h0;
            state <= lsq_pkg::SQ_EMIT;
            if (cmd_kind == lsq_pkg::KIND_STATUS) begin
              reply_len <= lsq_pkg::LEN_STATUS;
            end else if (w_data[lsq_pkg::CMD_SINGLE_BIT]) begin
              reply_len <= lsq_pkg::LEN_RAW_ONE;
            end else begin
              reply_len <= lsq_pkg::LEN_RAW_ALL;
            end
          end
        end
        lsq_pkg::SQ_EMIT: begin
          if ({1'b0, pos} == reply_len - 5'h02) begin
            state <= lsq_pkg::SQ_TERM;
          end
          pos <= pos + 4'h1;
        end
        lsq_pkg::SQ_TERM: begin
          state <= lsq_pkg::SQ_IDLE;
        end
      endcase
    end
  end

  assign busy = (state != lsq_pkg::SQ_IDLE);
  assign seq_finish = (state == lsq_pkg::SQ_TERM);

  // Reply buffer; the terminator lands right after the last body char
  always_ff @(posedge aclk) begin
    if (state == lsq_pkg::SQ_EMIT) begin
      reply_mem[pos] <= fmt_bus.ch;
    end else if (state == lsq_pkg::SQ_TERM) begin
      reply_mem[reply_len - 5'h01] <= lsq_pkg::CH_TERM;
    end
  end

  // Done is sticky; reading status clears it, but a finish wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done <= 1'b0;
    end else if (seq_finish) begin
      done <= 1'b1;
    end else if (status_read || cmd_write) begin
      done <= 1'b0;
    end
  end

  assign status_read = s_axi_arvalid && s_axi_arready
                       && s_axi_araddr == lsq_pkg::OFS_STATUS;

  // Read decode; buffer bytes beyond the reply read as zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = lsq_pkg::RESP_OKAY;
    if (s_axi_araddr >= lsq_pkg::OFS_REPLY0
        && s_axi_araddr < lsq_pkg::OFS_REPLY0
           + 8'(4 * lsq_pkg::REPLY_WORDS)
        && s_axi_araddr[1:0] == 2'h0) begin
      for (int b = 0; b < 4; b++) begin
        int k;
        k = int'(s_axi_araddr - lsq_pkg::OFS_REPLY0) + b;
        if (k < int'(reply_len) && !busy) begin
          next_rdata[8*b +: 8] = reply_mem[k];
        end
      end
    end else begin
      unique case (s_axi_araddr)
        lsq_pkg::OFS_CMD: begin
          next_rdata[lsq_pkg::CMD_KIND_LSB +: 2] = kind;
          next_rdata[lsq_pkg::CMD_SINGLE_BIT] = single;
          next_rdata[lsq_pkg::CMD_INDEX_LSB +: 3] = index;
        end
        lsq_pkg::OFS_STATUS: begin
          next_rdata[lsq_pkg::ST_BUSY_BIT] = busy;
          next_rdata[lsq_pkg::ST_DONE_BIT] = done;
          next_rdata[lsq_pkg::ST_LEN_LSB +: 5] = reply_len;
        end
        lsq_pkg::OFS_CONFIG: next_rdata = config_reg;
        lsq_pkg::OFS_PROCESSED: next_rdata[7:0] = processed;
        lsq_pkg::OFS_RAW: next_rdata[7:0] = levels;
        lsq_pkg::OFS_FLAGS: begin
          next_rdata[15:0] = {upper_flag, lower_flag, range_flag, cal_flag};
        end
        default: next_rresp = lsq_pkg::RESP_SLVERR;
      endcase
    end
  end

  // Read channel: answer registered one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= lsq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

/* File: tb/lsq_assertions.sv */
// Bus timing and register checker for the query block
`timescale 1ns/1ps
module lsq_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] x_limit_input_pair,
  input wire logic [1:0] y_limit_input_pair,
  input wire logic [1:0] z_limit_input_pair,
  input wire logic [1:0] a_limit_input_pair,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Handshake steps
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_B_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response not on time");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid stuck");
  AST_WR_REFUSE: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken early");
  AST_R_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data not on time");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken early");
  AST_UNMAPPED: assert property (rd_taken ##0 s_axi_araddr == 8'h18 |=>
    s_axi_rresp == lsq_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  AST_RAW_LEVEL: assert property (
    rd_taken ##0 s_axi_araddr == lsq_pkg::OFS_RAW |=>
    s_axi_rdata[7:0] == {$past(a_limit_input_pair),
    $past(z_limit_input_pair), $past(y_limit_input_pair),
    $past(x_limit_input_pair)}) else $error("raw levels");
endmodule

bind lsq_limit_status_query lsq_assertions chk (
  .aclk(aclk), .aresetn(aresetn),
  .x_limit_input_pair(x_limit_input_pair),
  .y_limit_input_pair(y_limit_input_pair),
  .z_limit_input_pair(z_limit_input_pair),
  .a_limit_input_pair(a_limit_input_pair),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* File: tb/lsq_motion_model.sv */
// Motion engine stand-in raising completion pulses
`timescale 1ns/1ps
module lsq_motion_model (
  input wire logic aclk,
  input wire logic go,
  input wire logic [1:0] axis,
  input wire logic [1:0] what,
  output logic [3:0] cal_done,
  output logic [3:0] range_done,
  output logic [3:0] lower_set,
  output logic [3:0] upper_set
);
  // One-cycle pulse, only on the chosen axis
  always_ff @(posedge aclk) begin
    cal_done <= (go && what == 2'h0) ? 4'h1 << axis : 4'h0;
    range_done <= (go && what == 2'h1) ? 4'h1 << axis : 4'h0;
    lower_set <= (go && what == 2'h2) ? 4'h1 << axis : 4'h0;
    upper_set <= (go && what == 2'h3) ? 4'h1 << axis : 4'h0;
  end
endmodule

/* File: tb/testbench.sv */
// Self-checking bench for the limit switch query block
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] lv = 8'h00;
  logic go = 1'b0;
  logic [1:0] axis = 2'h0;
  logic [1:0] what = 2'h0;
  logic [3:0] cal_done, range_done, lower_set, upper_set;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, cfg;
  logic [3:0] cal_e = 4'h0, rng_e = 4'h0, lo_e = 4'h0, up_e = 4'h0;
  logic [31:0] seed = 32'hF3D31EDF;
  int fails = 0, n_compared = 0, cyc = 0;

  lsq_limit_status_query dut (
    .aclk(aclk), .aresetn(aresetn),
    .x_limit_input_pair(lv[1:0]), .y_limit_input_pair(lv[3:2]),
    .z_limit_input_pair(lv[5:4]), .a_limit_input_pair(lv[7:6]),
    .cal_done(cal_done), .range_measure_command_done(range_done),
    .lower_limit_set(lower_set), .upper_limit_set(upper_set),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  lsq_motion_model eng (
    .aclk(aclk), .go(go), .axis(axis), .what(what),
    .cal_done(cal_done), .range_done(range_done),
    .lower_set(lower_set), .upper_set(upper_set));

  // 200 MHz clock
  always #2.5 aclk = ~aclk;

  // Hang guard, far above the roughly 1000 cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  task automatic conclude();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Processed view: polarity, then pair swap, then enable mask
  function automatic logic [7:0] proc(input logic [7:0] l,
                                      input logic [31:0] c);
    logic [7:0] p;
    p = l ^ c[15:8];
    for (int a = 0; a < 4; a++)
      if (c[16 + a] ^ c[20 + a])
        p[2 * a +: 2] = {p[2 * a], p[2 * a + 1]};
    return p & c[7:0];
  endfunction

  // Expected reply character at position p
  function automatic logic [7:0] xch(input logic [1:0] k,
                                     input logic [2:0] j, input int p);
    if (k == lsq_pkg::KIND_RAW)
      return lv[j] ? lsq_pkg::CH_ONE : lsq_pkg::CH_ZERO;
    case (p / 4)
      0: return cal_e[p % 4] ? lsq_pkg::CH_CAL : lsq_pkg::CH_DASH;
      1: return rng_e[p % 4] ? lsq_pkg::CH_RANGE : lsq_pkg::CH_DASH;
      2: return lo_e[p % 4] ? lsq_pkg::CH_LIMIT : lsq_pkg::CH_DASH;
      default:
        return up_e[p % 4] ? lsq_pkg::CH_LIMIT : lsq_pkg::CH_DASH;
    endcase
  endfunction

  // Write with both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Issue one query, wait for done, compare every reply byte
  task automatic query(input logic [1:0] k, input logic sg,
                       input logic [2:0] ix, input logic [4:0] len);
    logic [7:0] e;
    logic [31:0] rep [5];
    wr(lsq_pkg::OFS_CMD, {21'h0, ix, 3'h0, sg, 2'h0, k});
    do rd(lsq_pkg::OFS_STATUS); while (d[1] !== 1'b1);
    chk({27'h0, d[12:8]}, {27'h0, len});
    for (int w = 0; w < lsq_pkg::REPLY_WORDS; w++) begin
      rd(lsq_pkg::OFS_REPLY0 + 8'(4 * w));
      rep[w] = d;
    end
    for (int i = 0; i < 4 * lsq_pkg::REPLY_WORDS; i++) begin
      e = (i == len - 1) ? lsq_pkg::CH_TERM : 8'h00;
      if (i < len - 1)
        e = xch(k, sg ? ix : 3'(i), i);
      chk({24'h0, rep[i / 4][8 * (i % 4) +: 8]}, {24'h0, e});
    end
  endtask

  // Pulse one engine event and note it in the shadow flags
  task automatic ev(input logic [1:0] ax, input logic [1:0] wh);
    go <= 1'b1;
    axis <= ax;
    what <= wh;
    @(posedge aclk);
    go <= 1'b0;
    repeat (2) @(posedge aclk);
    case (wh)
      2'h0: cal_e[ax] = 1'b1;
      2'h1: rng_e[ax] = 1'b1;
      2'h2: lo_e[ax] = 1'b1;
      default: up_e[ax] = 1'b1;
    endcase
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    rd(lsq_pkg::OFS_CONFIG);
    chk(d, lsq_pkg::CFG_RESET);
    query(lsq_pkg::KIND_STATUS, 1'b0, 3'h0, lsq_pkg::LEN_STATUS);
    $display("test power-on status done");
    for (int it = 0; it < 4; it++) begin
      seed = lfsr(seed);
      lv <= (it == 0) ? 8'h01 : seed[7:0];
      cfg = seed & ((it == 3) ? 32'h00FF_FF00 : 32'h00FF_FFFF);
      wr(lsq_pkg::OFS_CONFIG, cfg);
      query(lsq_pkg::KIND_RAW, 1'b0, 3'h0, lsq_pkg::LEN_RAW_ALL);
      rd(lsq_pkg::OFS_PROCESSED);
      chk(d, {24'h0, proc(lv, cfg)});
      for (int i = 0; i < 8; i++)
        query(lsq_pkg::KIND_RAW, 1'b1, 3'(i), lsq_pkg::LEN_RAW_ONE);
    end
    $display("test raw levels done");
    ev(2'h0, 2'h0);
    ev(2'h3, 2'h1);
    ev(2'h1, 2'h2);
    ev(2'h2, 2'h3);
    ev(2'h0, 2'h3);
    query(lsq_pkg::KIND_STATUS, 1'b0, 3'h0, lsq_pkg::LEN_STATUS);
    $display("test status flags done");
    rd(8'h18);
    chk({30'h0, r}, {30'h0, lsq_pkg::RESP_SLVERR});
    wr(lsq_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    chk({30'h0, r}, {30'h0, lsq_pkg::RESP_SLVERR});
    rd(lsq_pkg::OFS_CONFIG);
    chk(d, cfg);
    // Unknown query kind must leave the sequencer idle and the reply length intact
    wr(lsq_pkg::OFS_CMD, 32'h0000_0003);
    rd(lsq_pkg::OFS_STATUS);
    chk(d, {19'h0, lsq_pkg::LEN_STATUS, 8'h00});
    $display("test bus errors done");
    conclude();
  end
endmodule
